// >>> shared/fde_pkg.sv
// fde_pkg: constants shared by the field-detect event select block
// assumes a 32-bit classic wishbone register bus with byte addresses
package fde_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] FDE_ADR_CFG = 8'h00;
   localparam logic [7:0] FDE_ADR_STATUS = 8'h04;
   localparam logic [7:0] FDE_ADR_IRQ_STAT = 8'h08;
   localparam logic [7:0] FDE_ADR_IRQ_MASK = 8'h0c;
   localparam logic [7:0] FDE_ADR_MIRROR_BASE = 8'h10;
   localparam logic [7:0] FDE_ADR_FINAL_BLOCK = 8'h14;
   // ----------------------------------------------------------------
   // configuration field layout
   // ----------------------------------------------------------------
   localparam int FDE_CFG_DIR = 0;
   localparam int FDE_CFG_MIRROR = 1;
   localparam int FDE_CFG_ASEL_LO = 2;
   localparam int FDE_CFG_RSEL_LO = 4;
   localparam int FDE_CFG_PTHRU = 6;
   localparam logic [7:0] FDE_CFG_WMASK = 8'h7f;
   localparam logic [7:0] FDE_CFG_RST = 8'h01;
   localparam logic [7:0] FDE_MIRROR_BASE_RST = 8'h00;
   localparam logic [7:0] FDE_FINAL_BLOCK_RST = 8'h00;
   // ----------------------------------------------------------------
   // status and interrupt bits
   // ----------------------------------------------------------------
   localparam int FDE_ST_FD = 0;
   localparam int FDE_ST_FIELD = 1;
   localparam int FDE_IRQ_N = 3;
   localparam int FDE_IRQ_ASSERT = 0;
   localparam int FDE_IRQ_RELEASE = 1;
   localparam int FDE_IRQ_FIELD_ON = 2;
   // ----------------------------------------------------------------
   // select codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FDE_ASEL_FIELD_ON = 2'h0,
      FDE_ASEL_SOC = 2'h1,
      FDE_ASEL_SELECTED = 2'h2,
      FDE_ASEL_BUFFER = 2'h3
   } fde_asel_e;
   typedef enum logic [1:0] {
      FDE_RSEL_FIELD_OFF = 2'h0,
      FDE_RSEL_HALT = 2'h1,
      FDE_RSEL_LAST_PAGE = 2'h2,
      FDE_RSEL_BUFFER = 2'h3
   } fde_rsel_e;
endpackage : fde_pkg

// >>> logic/fde_event_sel.sv
// fde_event_sel: turns engine event pulses into assert and release strobes
// assumes one-cycle event pulses synchronous to clk_i
`timescale 1ns/10ps
module fde_event_sel (
   input wire logic [1:0] asel_i,
   input wire logic [1:0] rsel_i,
   input wire logic dir_i,
   input wire logic pthru_i,
   input wire logic field_on_i,
   input wire logic field_off_i,
   input wire logic soc_i,
   input wire logic selected_i,
   input wire logic halt_i,
   input wire logic last_page_i,
   input wire logic reader_wr_done_i,
   input wire logic reader_rd_done_i,
   input wire logic host_rd_done_i,
   input wire logic host_wr_done_i,
   output logic assert_o,
   output logic release_o
);
   import fde_pkg::*;
   wire logic buf_ready = pthru_i & (dir_i ? reader_wr_done_i : reader_rd_done_i);
   wire logic buf_last = pthru_i & (dir_i ? host_rd_done_i : host_wr_done_i);
   always_comb begin
      case (fde_asel_e'(asel_i))
         FDE_ASEL_FIELD_ON: assert_o = field_on_i;
         FDE_ASEL_SOC: assert_o = soc_i;
         FDE_ASEL_SELECTED: assert_o = selected_i;
         FDE_ASEL_BUFFER: assert_o = buf_ready;
         default: assert_o = 1'b0;
      endcase
   end
   // field loss releases in every mode
   always_comb begin
      case (fde_rsel_e'(rsel_i))
         FDE_RSEL_FIELD_OFF: release_o = field_off_i;
         FDE_RSEL_HALT: release_o = field_off_i | halt_i;
         FDE_RSEL_LAST_PAGE: release_o = field_off_i | last_page_i;
         FDE_RSEL_BUFFER: release_o = field_off_i | ((asel_i == FDE_ASEL_BUFFER) & buf_last);
         default: release_o = field_off_i;
      endcase
   end
endmodule : fde_event_sel

// >>> logic/fde_irq_status.sv
// fde_irq_status: sticky event bits, mask and one level interrupt
// assumes write-one-to-clear strobes from the register slave
`timescale 1ns/10ps
module fde_irq_status #(
   parameter int N = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [N-1:0] set_i,
   input wire logic clr_we_i,
   input wire logic [N-1:0] clr_i,
   input wire logic [N-1:0] mask_i,
   output logic [N-1:0] status_o,
   output logic irq_o
);
   if (N < 1 || N > 8) begin : g_bad_n
      $error("fde_irq_status: N must be 1..8");
   end
   // ----------------------------------------------------------------
   // per-bit sticky flags, set beats clear
   // ----------------------------------------------------------------
   for (genvar b = 0; b < N; b++) begin : g_bit
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            status_o[b] <= 1'b0;
         end else if (set_i[b]) begin
            status_o[b] <= 1'b1;
         end else if (clr_we_i && clr_i[b]) begin
            status_o[b] <= 1'b0;
         end
      end
   end
   wire logic [N-1:0] next_status = set_i | (status_o & ~({N{clr_we_i}} & clr_i));
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(next_status & mask_i);
      end
   end
endmodule : fde_irq_status

// >>> logic/fde_field_detect.sv
// fde_field_detect: field-detect output control with configuration registers
// assumes engine event pulses synchronous to clk_i; host side on wishbone,
// reader side through a simple write strobe and the cfg_o readback
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - two-bit assert select field, reset zero, picks the pull-low event.
// - assert select 00 pulls output low when the rf field appears.
// - assert select 01 pulls low on first valid start of communication.
// - assert select 10 pulls low when the tag gets selected.
// - assert select 11, reader to host: pull low when buffer ready for host.
// - assert select 11, host to reader: pull low after reader read buffer.
// - release select 01 releases on field loss or halt.
// - release select 10 releases on field loss or final message page read.
// - both selects 11: release on field loss or last host buffer access.
// - release 11 with assert not 11 releases only on field loss.
// - pass-through enable maps buffer to end of sector zero; resets zero.
// - mirror enable mirrors buffer into user memory from configured base.
// - direction bit 1 reader to host, 0 host to reader; resets one.
module fde_field_detect (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic reader_cfg_we_i,
   input wire logic [7:0] reader_cfg_wdata_i,
   output logic [7:0] cfg_o,
   input wire logic field_on_i,
   input wire logic field_off_i,
   input wire logic soc_i,
   input wire logic selected_i,
   input wire logic halt_i,
   input wire logic reader_page_read_i,
   input wire logic [7:0] reader_page_i,
   input wire logic reader_wr_done_i,
   input wire logic reader_rd_done_i,
   input wire logic host_rd_done_i,
   input wire logic host_wr_done_i,
   output logic field_detect_out_o,
   output logic field_detect_oe_o,
   output logic [7:0] mirror_base_o,
   output logic [7:0] final_message_block_o,
   output logic irq_o
);
   import fde_pkg::*;

   // ----------------------------------------------------------------
   // configuration fields
   // ----------------------------------------------------------------
   wire logic dir = cfg_o[FDE_CFG_DIR];
   wire logic mirror_enable = cfg_o[FDE_CFG_MIRROR];
   wire logic [1:0] detect_assert_select = cfg_o[FDE_CFG_ASEL_LO +: 2];
   wire logic [1:0] detect_release_select = cfg_o[FDE_CFG_RSEL_LO +: 2];
   wire logic passthru_enable = cfg_o[FDE_CFG_PTHRU];

   // ----------------------------------------------------------------
   // wishbone decode
   // ----------------------------------------------------------------
   // one wait state: ack registered, write lands on the ack edge
   wire logic wb_req = wb_cyc_i & wb_stb_i;
   wire logic wb_wr = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
   wire logic sel_cfg = (wb_adr_i == FDE_ADR_CFG);
   wire logic sel_status = (wb_adr_i == FDE_ADR_STATUS);
   wire logic sel_irq_stat = (wb_adr_i == FDE_ADR_IRQ_STAT);
   wire logic sel_irq_mask = (wb_adr_i == FDE_ADR_IRQ_MASK);
   wire logic sel_mirror = (wb_adr_i == FDE_ADR_MIRROR_BASE);
   wire logic sel_final = (wb_adr_i == FDE_ADR_FINAL_BLOCK);
   wire logic host_cfg_we = wb_wr & sel_cfg;
   wire logic irq_clr_we = wb_wr & sel_irq_stat;

   logic field_present;
   logic [FDE_IRQ_N-1:0] irq_mask;
   logic [FDE_IRQ_N-1:0] irq_status;

   wire logic [7:0] status_word = {6'h00, field_present, field_detect_oe_o};
   wire logic [7:0] rd_byte = sel_cfg ? cfg_o :
      sel_status ? status_word :
      sel_irq_stat ? {5'h00, irq_status} :
      sel_irq_mask ? {5'h00, irq_mask} :
      sel_mirror ? mirror_base_o :
      sel_final ? final_message_block_o : 8'h00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         wb_dat_o <= {24'h00_0000, rd_byte};
      end
   end

   // ----------------------------------------------------------------
   // configuration register, shared by both sides
   // ----------------------------------------------------------------
   // a host write in the same cycle as a reader write wins; no arbitration
   wire logic [7:0] next_cfg = host_cfg_we ? (wb_dat_i[7:0] & FDE_CFG_WMASK) :
      reader_cfg_we_i ? (reader_cfg_wdata_i & FDE_CFG_WMASK) : cfg_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_o <= FDE_CFG_RST;
      end else begin
         cfg_o <= next_cfg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mirror_base_o <= FDE_MIRROR_BASE_RST;
         final_message_block_o <= FDE_FINAL_BLOCK_RST;
         irq_mask <= '0;
      end else begin
         if (wb_wr && sel_mirror) mirror_base_o <= wb_dat_i[7:0];
         if (wb_wr && sel_final) final_message_block_o <= wb_dat_i[7:0];
         if (wb_wr && sel_irq_mask) irq_mask <= wb_dat_i[FDE_IRQ_N-1:0];
      end
   end

   // ----------------------------------------------------------------
   // event selection
   // ----------------------------------------------------------------
   logic assert_evt;
   logic release_evt;
   wire logic last_page = reader_page_read_i & (reader_page_i == final_message_block_o);

   fde_event_sel u_sel (
      .asel_i(detect_assert_select),
      .rsel_i(detect_release_select),
      .dir_i(dir),
      .pthru_i(passthru_enable),
      .field_on_i(field_on_i),
      .field_off_i(field_off_i),
      .soc_i(soc_i),
      .selected_i(selected_i),
      .halt_i(halt_i),
      .last_page_i(last_page),
      .reader_wr_done_i(reader_wr_done_i),
      .reader_rd_done_i(reader_rd_done_i),
      .host_rd_done_i(host_rd_done_i),
      .host_wr_done_i(host_wr_done_i),
      .assert_o(assert_evt),
      .release_o(release_evt)
   );

   // ----------------------------------------------------------------
   // field-detect output
   // ----------------------------------------------------------------
   // open drain: the pin only ever drives low, so data stays zero
   // release beats a same-cycle assert, so a lost field never leaves it low
   wire logic fd_set = ~field_detect_oe_o & assert_evt & ~release_evt;
   wire logic fd_clr = field_detect_oe_o & release_evt;
   wire logic next_fd = fd_set | (field_detect_oe_o & ~release_evt);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         field_detect_oe_o <= 1'b0;
         field_detect_out_o <= 1'b0;
         field_present <= 1'b0;
      end else begin
         field_detect_oe_o <= next_fd;
         field_detect_out_o <= 1'b0;
         if (field_on_i) field_present <= 1'b1;
         else if (field_off_i) field_present <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   wire logic [FDE_IRQ_N-1:0] irq_set = {field_on_i, fd_clr, fd_set};

   fde_irq_status #(
      .N(FDE_IRQ_N)
   ) u_irq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(irq_set),
      .clr_we_i(irq_clr_we),
      .clr_i(wb_dat_i[FDE_IRQ_N-1:0]),
      .mask_i(irq_mask),
      .status_o(irq_status),
      .irq_o(irq_o)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   wire logic idle = ~field_detect_oe_o & ~release_evt;

   sequence s_host_cfg_write;
      wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && sel_cfg && !wb_ack_o ##1 wb_ack_o;
   endsequence

   property p_reset_values;
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> cfg_o == 8'h01 && !field_detect_oe_o && !irq_o;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

   property p_assert_field_on;
      idle && detect_assert_select == 2'h0 && field_on_i |=> field_detect_oe_o;
   endproperty
   a_assert_field_on: assert property (p_assert_field_on) else $error("field on did not assert");

   property p_assert_soc;
      idle && detect_assert_select == 2'h1 && soc_i |=> field_detect_oe_o;
   endproperty
   a_assert_soc: assert property (p_assert_soc) else $error("soc did not assert");

   property p_assert_select;
      idle && detect_assert_select == 2'h2 && selected_i |=> field_detect_oe_o;
   endproperty
   a_assert_select: assert property (p_assert_select) else $error("selection did not assert");

   property p_assert_buf_r2h;
      idle && detect_assert_select == 2'h3 && passthru_enable && dir && reader_wr_done_i |=> field_detect_oe_o;
   endproperty
   a_assert_buf_r2h: assert property (p_assert_buf_r2h) else $error("buffer ready did not assert");

   property p_assert_buf_h2r;
      idle && detect_assert_select == 2'h3 && passthru_enable && !dir && reader_rd_done_i |=> field_detect_oe_o;
   endproperty
   a_assert_buf_h2r: assert property (p_assert_buf_h2r) else $error("reader read did not assert");

   property p_release_field_off;
      field_detect_oe_o && field_off_i |=> !field_detect_oe_o;
   endproperty
   a_release_field_off: assert property (p_release_field_off) else $error("field loss did not release");

   property p_release_halt;
      field_detect_oe_o && detect_release_select == 2'h1 && halt_i |=> !field_detect_oe_o;
   endproperty
   a_release_halt: assert property (p_release_halt) else $error("halt did not release");

   property p_release_last_page;
      field_detect_oe_o && detect_release_select == 2'h2 && reader_page_read_i &&
         reader_page_i == final_message_block_o |=> !field_detect_oe_o;
   endproperty
   a_release_last_page: assert property (p_release_last_page) else $error("last page did not release");

   property p_release_buf;
      field_detect_oe_o && cfg_o[5:2] == 4'hf && passthru_enable &&
         (dir ? host_rd_done_i : host_wr_done_i) |=> !field_detect_oe_o;
   endproperty
   a_release_buf: assert property (p_release_buf) else $error("last host access did not release");

   property p_release_only_field;
      field_detect_oe_o && detect_release_select == 2'h3 && detect_assert_select != 2'h3 &&
         !field_off_i |=> field_detect_oe_o;
   endproperty
   a_release_only_field: assert property (p_release_only_field) else $error("released without field loss");

   property p_hold;
      field_detect_oe_o && !release_evt ##1 !release_evt |=> field_detect_oe_o;
   endproperty
   a_hold: assert property (p_hold) else $error("output dropped without release");

   property p_no_assert_when_disabled;
      !field_detect_oe_o && detect_assert_select == 2'h3 && !passthru_enable |=> !field_detect_oe_o;
   endproperty
   a_no_assert_when_disabled: assert property (p_no_assert_when_disabled)
      else $error("buffer assert w/o passthru");

   property p_host_cfg_write;
      s_host_cfg_write |=> cfg_o == ($past(wb_dat_i[7:0]) & 8'h7f);
   endproperty
   a_host_cfg_write: assert property (p_host_cfg_write) else $error("host config write lost");

   property p_reader_cfg_write;
      reader_cfg_we_i && !host_cfg_we |=> cfg_o == ($past(reader_cfg_wdata_i) & 8'h7f) &&
         mirror_enable == $past(reader_cfg_wdata_i[1]);
   endproperty
   a_reader_cfg_write: assert property (p_reader_cfg_write) else $error("reader config write lost");

   property p_dir_kept;
      !reader_cfg_we_i && !host_cfg_we |=> $stable(dir);
   endproperty
   a_dir_kept: assert property (p_dir_kept) else $error("direction changed without write");

   sequence s_host_cfg_read;
      wb_req && !wb_we_i && sel_cfg && !wb_ack_o;
   endsequence

   property p_host_cfg_read;
      s_host_cfg_read |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(cfg_o)};
   endproperty
   a_host_cfg_read: assert property (p_host_cfg_read) else $error("host config read wrong");

   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

   property p_ack_follows;
      wb_req && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_follows: assert property (p_ack_follows) else $error("request not acknowledged");

   property p_asel0_quiet;
      !field_detect_oe_o && detect_assert_select == 2'h0 && !field_on_i |=> !field_detect_oe_o;
   endproperty
   a_asel0_quiet: assert property (p_asel0_quiet) else $error("asserted without field on");

   property p_asel3_r2h_quiet;
      !field_detect_oe_o && detect_assert_select == 2'h3 && passthru_enable && dir &&
         !reader_wr_done_i |=> !field_detect_oe_o;
   endproperty
   a_asel3_r2h_quiet: assert property (p_asel3_r2h_quiet) else $error("asserted without buffer ready");

   property p_asel3_h2r_quiet;
      !field_detect_oe_o && detect_assert_select == 2'h3 && passthru_enable && !dir &&
         !reader_rd_done_i |=> !field_detect_oe_o;
   endproperty
   a_asel3_h2r_quiet: assert property (p_asel3_h2r_quiet) else $error("asserted without reader read");

   property p_rsel0_hold;
      field_detect_oe_o && detect_release_select == 2'h0 && !field_off_i |=> field_detect_oe_o;
   endproperty
   a_rsel0_hold: assert property (p_rsel0_hold) else $error("released without field loss");

   property p_rsel2_hold;
      field_detect_oe_o && detect_release_select == 2'h2 && !field_off_i &&
         !(reader_page_read_i && reader_page_i == final_message_block_o) |=> field_detect_oe_o;
   endproperty
   a_rsel2_hold: assert property (p_rsel2_hold) else $error("released before last page");

   property p_buf_hold_nopass;
      field_detect_oe_o && cfg_o[5:2] == 4'hf && !passthru_enable && !field_off_i |=> field_detect_oe_o;
   endproperty
   a_buf_hold_nopass: assert property (p_buf_hold_nopass) else $error("buffer release w/o passthru");

   property p_assert_flag;
      fd_set |=> field_detect_oe_o && irq_status[FDE_IRQ_ASSERT];
   endproperty
   a_assert_flag: assert property (p_assert_flag) else $error("assert event not flagged");

endmodule : fde_field_detect

// >>> testbench/fde_host_model.sv
// fde_host_model: host controller side of the open-drain field-detect line
// assumes a pull-up on the line and the pin split into data and enable
`timescale 1ns/10ps
module fde_host_model (
   input wire logic clk_i,
   input wire logic fd_out_i,
   input wire logic fd_oe_i,
   output logic fd_level_o,
   output logic [7:0] falls_o
);
   // ----------------------------------------------------------------
   // line level and wake-up count
   // ----------------------------------------------------------------
   logic prev = 1'h1;
   logic [7:0] falls = 8'h00;
   // released line floats up to the pull-up, never holds the last value
   assign fd_level_o = fd_oe_i ? fd_out_i : 1'h1;
   assign falls_o = falls;
   // every falling edge is one wake-up of the host
   always_ff @(posedge clk_i) begin
      prev <= fd_level_o;
      if (prev && !fd_level_o) begin
         falls <= falls + 8'h01;
      end
   end
endmodule : fde_host_model

// >>> testbench/testbench.sv
// testbench: self-checking bench for fde_field_detect
// assumes the host model sees the pin; reads are checked from a queue of notes
`timescale 1ns/10ps
module testbench;
   import fde_pkg::*;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, reader_cfg_we_i = 1'h0, fld = 1'h0;
   logic [7:0] wb_adr_i = 8'h00, reader_cfg_wdata_i = 8'h00, reader_page_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d, seed = 32'h40;
   logic wb_ack_o, fd_out, fd_oe, irq_o, pin;
   logic [7:0] cfg_o, mb_o, fb_o, falls;
   logic [9:0] ev = 10'h000;
   logic [31:0] exp_q[$];
   int bad_count = 0, num_checks = 0, cycles = 0;
   // ----------------------------------------------------------------
   // clock, design and host model
   // ----------------------------------------------------------------
   initial forever #20 clk_i = ~clk_i;
   fde_field_detect dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reader_cfg_we_i(reader_cfg_we_i),
      .reader_cfg_wdata_i(reader_cfg_wdata_i), .cfg_o(cfg_o), .field_on_i(ev[0]), .field_off_i(ev[1]),
      .soc_i(ev[2]), .selected_i(ev[3]), .halt_i(ev[4]), .reader_page_read_i(ev[5]),
      .reader_page_i(reader_page_i), .reader_wr_done_i(ev[6]), .reader_rd_done_i(ev[7]),
      .host_rd_done_i(ev[8]), .host_wr_done_i(ev[9]), .field_detect_out_o(fd_out),
      .field_detect_oe_o(fd_oe), .mirror_base_o(mb_o), .final_message_block_o(fb_o), .irq_o(irq_o));
   fde_host_model host (.clk_i(clk_i), .fd_out_i(fd_out), .fd_oe_i(fd_oe), .fd_level_o(pin),
      .falls_o(falls));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done
   // classic cycle: hold until ack seen, release at the sampling edge
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      do @(posedge clk_i); while (wb_ack_o !== 1'h1);
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      // let the landed write settle before callers look at outputs
      @(negedge clk_i);
   endtask : wb
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      exp_q.push_back(exp);
      wb(1'h0, adr, 32'h0);
   endtask : rd
   task automatic cfg(input logic [1:0] asel, input logic [1:0] rsel, input logic pth, input logic dir);
      wb(1'h1, FDE_ADR_CFG, {24'h0, 1'h0, pth, rsel, asel, 1'h0, dir});
   endtask : cfg
   task automatic pulse(input int i);
      @(posedge clk_i);
      ev[i] <= 1'h1;
      @(posedge clk_i);
      ev[i] <= 1'h0;
      if (i == 0) fld = 1'h1;
      if (i == 1) fld = 1'h0;
      repeat (2) @(posedge clk_i);
   endtask : pulse
   // status read plus the level the host sees on the line
   task automatic st(input logic oe);
      rd(FDE_ADR_STATUS, {30'h0, fld, oe});
      chk({31'h0, pin}, {31'h0, ~oe});
   endtask : st
   // ----------------------------------------------------------------
   // read monitor and timeout
   // ----------------------------------------------------------------
   always @(negedge clk_i) begin
      if (wb_ack_o === 1'h1 && wb_we_i === 1'h0 && exp_q.size() > 0) begin
         chk(wb_dat_o, exp_q.pop_front());
      end
   end
   // whole run needs well under 5000 cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'h0;
      rd(FDE_ADR_CFG, {24'h0, FDE_CFG_RST});
      rd(FDE_ADR_MIRROR_BASE, 32'h0);
      rd(8'h40, 32'h0);
      chk({31'h0, pin}, 32'h1);
      $display("test reset values done");
      for (int k = 0; k < 4; k++) begin
         d = rnd();
         wb(1'h1, FDE_ADR_CFG, d);
         rd(FDE_ADR_CFG, {24'h0, d[7:0] & FDE_CFG_WMASK});
         @(posedge clk_i);
         reader_cfg_we_i <= 1'h1;
         reader_cfg_wdata_i <= ~d[7:0];
         @(posedge clk_i);
         reader_cfg_we_i <= 1'h0;
         @(posedge clk_i);
         chk({24'h0, cfg_o}, {24'h0, ~d[7:0] & FDE_CFG_WMASK});
         wb(1'h1, FDE_ADR_MIRROR_BASE, d);
         chk({24'h0, mb_o}, {24'h0, d[7:0]});
      end
      $display("test config access done");
      wb(1'h1, FDE_ADR_IRQ_MASK, 32'h1);
      for (int a = 0; a < 3; a++) begin
         cfg(a[1:0], 2'h0, 1'h0, 1'h1);
         pulse(a == 0 ? 0 : a + 1);
         st(1'h1);
         chk({31'h0, irq_o}, 32'h1);
         pulse(4);
         st(1'h1);
         pulse(a == 0 ? 0 : a + 1);
         pulse(1);
         st(1'h0);
         wb(1'h1, FDE_ADR_IRQ_STAT, 32'h7);
         @(negedge clk_i);
         chk({31'h0, irq_o}, 32'h0);
      end
      chk({24'h0, falls}, 32'h3);
      wb(1'h1, FDE_ADR_IRQ_MASK, 32'h0);
      cfg(2'h0, 2'h1, 1'h0, 1'h1);
      pulse(0);
      chk({31'h0, irq_o}, 32'h0);
      pulse(4);
      st(1'h0);
      $display("test assert events done");
      d = rnd();
      wb(1'h1, FDE_ADR_FINAL_BLOCK, d);
      chk({24'h0, fb_o}, {24'h0, d[7:0]});
      cfg(2'h0, 2'h2, 1'h0, 1'h1);
      pulse(0);
      reader_page_i <= d[7:0] ^ 8'h01;
      pulse(5);
      st(1'h1);
      reader_page_i <= d[7:0];
      pulse(5);
      st(1'h0);
      pulse(1);
      $display("test release events done");
      cfg(2'h3, 2'h3, 1'h0, 1'h1);
      pulse(6);
      st(1'h0);
      cfg(2'h3, 2'h3, 1'h1, 1'h1);
      pulse(6);
      st(1'h1);
      cfg(2'h3, 2'h3, 1'h0, 1'h1);
      pulse(8);
      st(1'h1);
      cfg(2'h3, 2'h3, 1'h1, 1'h1);
      pulse(8);
      st(1'h0);
      cfg(2'h3, 2'h3, 1'h1, 1'h0);
      pulse(7);
      st(1'h1);
      pulse(9);
      st(1'h0);
      cfg(2'h0, 2'h3, 1'h1, 1'h1);
      pulse(0);
      pulse(8);
      st(1'h1);
      pulse(1);
      st(1'h0);
      $display("test buffer events done");
      test_done();
   end
endmodule : testbench
